// ### rtl/stc_map.vh
// Constants for the serial trace capture unit
`ifndef STC_MAP_VH
`define STC_MAP_VH
`define STC_STORE_BYTES      1024
`define STC_DIR_BYTES        114
`define STC_DATA_BYTES       910
`define STC_DEF_PKT_COUNT    16'h0001
`define STC_DEF_BYTE_COUNT   16'h0004
`define STC_FIFO_DEPTH       32
`define STC_MODE_PKT         2'h0
`define STC_MODE_BYTE        2'h1
`define STC_MODE_PKT_BYTE    2'h2
`define STC_MODE_BYTE_PKT    2'h3
`endif

// ### rtl/stc_fifo.v
// Synchronous valid/ready FIFO for captured trace items
`timescale 1ns/1ps
module stc_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  // Full and empty from occupancy count
  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage array, no reset needed
  always @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers wrap at DEPTH
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule // stc_fifo

// ### rtl/stc_trace.v
// Serial byte trace capture: trigger search and 1K trace store
`timescale 1ns/1ps
`include "stc_map.vh"
module stc_trace #(
  parameter DATA_BYTES = `STC_DATA_BYTES,
  parameter DIR_BYTES  = `STC_DIR_BYTES,
  parameter FIFO_DEPTH = `STC_FIFO_DEPTH
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        tx_valid,
  input  wire [7:0]  tx_data,
  input  wire        pkt_start,
  input  wire [7:0]  pkt_opcode,
  input  wire        cfg_write,
  input  wire [1:0]  cfg_mode,
  input  wire        cfg_pkt_count_given,
  input  wire [15:0] cfg_pkt_count,
  input  wire        cfg_opcode_given,
  input  wire [7:0]  cfg_opcode,
  input  wire        cfg_byte_count_given,
  input  wire [15:0] cfg_byte_count,
  input  wire        cfg_value_given,
  input  wire [7:0]  cfg_value,
  input  wire        cmd_on,
  input  wire        cmd_off,
  input  wire        cmd_reset,
  input  wire [9:0]  rd_addr,
  output reg  [7:0]  rd_data,
  output reg         rd_dir,
  output reg         armed,
  output reg         capturing,
  output reg         full,
  output reg  [9:0]  fill_level,
  output reg         overrun
);
  // Search/capture states, one-hot
  localparam [3:0] ST_IDLE  = 4'h1;
  localparam [3:0] ST_FIRST = 4'h2;
  localparam [3:0] ST_SECND = 4'h4;
  localparam [3:0] ST_CAPT  = 4'h8;

  reg  [3:0]  state_q;
  reg  [1:0]  mode_q;
  reg  [15:0] pkt_goal_q;
  reg  [15:0] byte_goal_q;
  reg         op_any_q;
  reg  [7:0]  op_q;
  reg         val_any_q;
  reg  [7:0]  val_q;
  reg  [15:0] pkt_cnt_q;
  reg  [15:0] byte_cnt_q;
  reg  [7:0]  data_mem [0:DATA_BYTES-1];
  reg  [7:0]  dir_mem  [0:DIR_BYTES-1];
  reg  [9:0]  wr_ptr_q;
  reg  [9:0]  slots_q;
  reg         drain_q;

  wire        any_byte;
  wire [7:0]  sel_byte;
  wire        sel_dir;
  wire        pkt_hit;
  wire        byte_hit;
  wire        pkt_done;
  wire        byte_done;
  wire        fire;
  wire        rearm;
  wire        f_in_valid;
  wire        f_in_ready;
  wire [8:0]  f_out_data;
  wire        f_out_valid;
  wire        f_out_ready;
  wire        store_wr;
  wire        store_last;
  wire        restart_full;
  wire [9:0]  dir_idx;
  reg  [7:0]  dir_word;

  // Count limit reached test, shared by both conditions
  function reached;
    input [15:0] cnt;
    input        hit;
    input [15:0] goal;
    begin
      reached = hit && ((cnt + 16'h0001) >= goal);
    end
  endfunction

  // Pick one byte per cycle; rx wins if both strobe together, tx lost
  // and flagged as overrun in the capture state, since the port is half-duplex in practice
  assign any_byte = rx_valid | tx_valid;
  assign sel_byte = rx_valid ? rx_data : tx_data;
  assign sel_dir  = rx_valid ? 1'b0 : 1'b1;      // 0 receive, 1 transmit

  // Packet and byte matches
  assign pkt_hit  = pkt_start & (op_any_q | (pkt_opcode == op_q));
  assign byte_hit = any_byte & (val_any_q | (sel_byte == val_q));
  assign pkt_done  = reached(pkt_cnt_q, pkt_hit, pkt_goal_q);
  assign byte_done = reached(byte_cnt_q, byte_hit, byte_goal_q);

  // Fire on the completing event of the last stage
  assign fire = (state_q == ST_FIRST &&
                 ((mode_q == `STC_MODE_PKT  && pkt_done) ||
                  (mode_q == `STC_MODE_BYTE && byte_done))) ||
                (state_q == ST_SECND &&
                 (((mode_q == `STC_MODE_PKT_BYTE) && byte_done) ||
                  ((mode_q == `STC_MODE_BYTE_PKT) && pkt_done)));

  assign rearm = cfg_write | cmd_on | cmd_reset;

  // Capture path: triggering byte goes in too, so the trace starts with it.
  // A byte only enters while a store slot is still unreserved; counting
  // reservations, not written slots, keeps a late byte from being
  // parked in the FIFO and landing in the next trace. Bytes in the
  // cycle of a command stay out, as the command stops or restarts the search.
  assign f_in_valid = any_byte & (fire | state_q == ST_CAPT) &
                      ~cmd_off & ~rearm &
                      (slots_q != DATA_BYTES[9:0]);
  // No drain in a clearing cycle, so no popped byte is lost
  assign f_out_ready = drain_q && ~cmd_reset &&
                       (wr_ptr_q != DATA_BYTES[9:0]);
  assign store_wr     = f_out_valid & f_out_ready;
  assign store_last   = store_wr & (wr_ptr_q == DATA_BYTES[9:0] - 10'h001);
  assign restart_full = (cfg_write | cmd_on) & full;

  stc_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_data   ({sel_dir, sel_byte}),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .out_data  (f_out_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready)
  );

  // Configuration; defaults apply when a field was not given
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode_q      <= `STC_MODE_BYTE;
      pkt_goal_q  <= `STC_DEF_PKT_COUNT;
      byte_goal_q <= `STC_DEF_BYTE_COUNT;
      op_any_q    <= 1'b1;
      op_q        <= 8'h00;
      val_any_q   <= 1'b1;
      val_q       <= 8'h00;
    end
    else if (cfg_write)
    begin
      mode_q      <= cfg_mode;
      pkt_goal_q  <= cfg_pkt_count_given ? cfg_pkt_count
                                         : `STC_DEF_PKT_COUNT;
      byte_goal_q <= cfg_byte_count_given ? cfg_byte_count
                                          : `STC_DEF_BYTE_COUNT;
      op_any_q    <= ~cfg_opcode_given;
      op_q        <= cfg_opcode;
      val_any_q   <= ~cfg_value_given;
      val_q       <= cfg_value;
    end
  end

  // Trigger search state machine and counters
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= ST_IDLE;
      pkt_cnt_q  <= 16'h0000;
      byte_cnt_q <= 16'h0000;
    end
    else if (cmd_off)
      state_q <= ST_IDLE;
    else if (rearm)
    begin
      state_q    <= ST_FIRST;
      pkt_cnt_q  <= 16'h0000;
      byte_cnt_q <= 16'h0000;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
          state_q <= ST_IDLE;
        ST_FIRST:
        begin
          if (fire)
            state_q <= ST_CAPT;
          else if (mode_q == `STC_MODE_PKT_BYTE ||
                   mode_q == `STC_MODE_PKT)
          begin
            if (pkt_done && mode_q == `STC_MODE_PKT_BYTE)
              state_q <= ST_SECND;
            else if (pkt_hit)
              pkt_cnt_q <= pkt_cnt_q + 16'h0001;
          end
          else
          begin
            if (byte_done && mode_q == `STC_MODE_BYTE_PKT)
              state_q <= ST_SECND;
            else if (byte_hit)
              byte_cnt_q <= byte_cnt_q + 16'h0001;
          end
        end
        ST_SECND:
        begin
          if (fire)
            state_q <= ST_CAPT;
          else if (mode_q == `STC_MODE_PKT_BYTE && byte_hit)
            byte_cnt_q <= byte_cnt_q + 16'h0001;
          else if (mode_q == `STC_MODE_BYTE_PKT && pkt_hit)
            pkt_cnt_q <= pkt_cnt_q + 16'h0001;
        end
        ST_CAPT:
          state_q <= ST_CAPT;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Store writes: data byte plus its direction bit packed 8 per byte
  assign dir_idx = {3'b000, wr_ptr_q[9:3]};
  always @(posedge clk)
  begin
    if (f_out_valid && f_out_ready)
    begin
      data_mem[wr_ptr_q] <= f_out_data[7:0];
      dir_mem[dir_idx[6:0]] <= dir_word;
    end
  end

  // Read-modify of the direction byte for the current slot
  always @*
  begin
    dir_word = dir_mem[dir_idx[6:0]];
    dir_word[wr_ptr_q[2:0]] = f_out_data[8];
  end

  // Write pointer, drain control and status flags
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q   <= 10'h000;
      slots_q    <= 10'h000;
      drain_q    <= 1'b0;
      armed      <= 1'b0;
      capturing  <= 1'b0;
      full       <= 1'b0;
      fill_level <= 10'h000;
      overrun    <= 1'b0;
    end
    else
    begin
      // Drain runs in every state once out of reset; off leaves the FIFO contents
      // to finish so already-seen bytes are kept in the store
      if (cmd_reset)
      begin
        wr_ptr_q <= 10'h000;
        slots_q  <= 10'h000;
        full     <= 1'b0;
        overrun  <= 1'b0;
      end
      else if (restart_full)
      begin
        // Full store restarts on re-arm; a part-filled one appends
        wr_ptr_q <= 10'h000;
        slots_q  <= 10'h000;
        full     <= 1'b0;
      end
      else
      begin
        // Pushes and pops are gated off in clearing cycles
        if (store_wr)
          wr_ptr_q <= wr_ptr_q + 10'h001;
        if (store_last)
          full <= 1'b1;
        if (f_in_valid && f_in_ready)
          slots_q <= slots_q + 10'h001;
      end
      drain_q    <= 1'b1;
      armed      <= (state_q == ST_FIRST) | (state_q == ST_SECND);
      // Drop capturing in the cycle that full rises, so the two
      // levels are never seen together
      capturing  <= (state_q == ST_CAPT) & ~full & ~store_last;
      fill_level <= wr_ptr_q;
      if ((f_in_valid & ~f_in_ready) |
          (rx_valid & tx_valid & (state_q == ST_CAPT)))
        overrun <= 1'b1;       // Set wins, cleared only by reset command
    end
  end

  // Registered readback of the store
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data <= 8'h00;
      rd_dir  <= 1'b0;
    end
    else
    begin
      // Beyond the last data slot both read as zero; the direction
      // array has spare bits there that are never written
      if (rd_addr < DATA_BYTES[9:0])
      begin
        rd_data <= data_mem[rd_addr];
        rd_dir  <= dir_mem[rd_addr[9:3]][rd_addr[2:0]];
      end
      else
      begin
        rd_data <= 8'h00;
        rd_dir  <= 1'b0;
      end
    end
  end
endmodule // stc_trace

// ### testbench/stc_trace_sva.sv
// Assertion checker for the serial trace capture unit
`timescale 1ns/1ps
module stc_trace_sva (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       cfg_write,
  input wire logic       cmd_on,
  input wire logic       cmd_off,
  input wire logic       cmd_reset,
  input wire logic       armed,
  input wire logic       capturing,
  input wire logic       full,
  input wire logic [9:0] fill_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Any re-arming request, for the fall of full
  wire rearm = cmd_on | cmd_reset | cfg_write;
  // Arming, stopping and clearing answer within their latency
  cfg_arm_a: assert property (cfg_write && !cmd_off |-> ##[2:3] armed)
    else $error("setup did not arm");
  on_arm_a: assert property (cmd_on && !cmd_off |-> ##[2:3] armed)
    else $error("enable did not arm");
  off_stop_a: assert property (cmd_off |-> ##[2:3] !armed && !capturing)
    else $error("disable did not stop");
  rst_clear_a: assert property (cmd_reset && !cmd_off |-> ##[1:3] fill_level == 10'h000)
    else $error("reset kept data");
  // Store size and full behaviour
  full_stop_a: assert property (full |-> !capturing)
    else $error("capture while full");
  full_hold_a: assert property ($fell(full) |-> $past(rearm) || $past(rearm, 2) || $past(rearm, 3))
    else $error("full left without re-arm");
  fill_max_a: assert property (fill_level <= 10'h38e)
    else $error("fill beyond store");
  fill_full_a: assert property ($rose(full) |=> fill_level == 10'h38e)
    else $error("full at wrong level");
  // Main scenarios reached
  fire_c: cover property ($rose(capturing));
  full_c: cover property ($rose(full));
  off_c: cover property (capturing ##1 cmd_off);
endmodule // stc_trace_sva

bind stc_trace stc_trace_sva i_stc_trace_sva (.clk, .reset_n, .cfg_write,
  .cmd_on, .cmd_off, .cmd_reset, .armed, .capturing, .full, .fill_level);

// ### testbench/stc_laptop.sv
// Laptop model sending received bytes and packet marks
`timescale 1ns/1ps
module stc_laptop (
  input  wire       clk,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        pkt_start,
  output reg  [7:0] pkt_opcode
);
  // Idle link at time zero
  initial
  begin
    {rx_valid, pkt_start} = 2'h0;
    {rx_data, pkt_opcode} = 16'h0000;
  end
  // One byte for one clock; idle data inverted so no stale value shows
  task send(input [7:0] b, input p);
  begin
    @(posedge clk);
    rx_valid   <= 1'b1;
    rx_data    <= b;
    pkt_start  <= p;
    pkt_opcode <= b;
    @(posedge clk);
    {rx_valid, pkt_start} <= 2'h0;
    rx_data    <= ~b;
    pkt_opcode <= ~b;
  end
  endtask
endmodule // stc_laptop

// ### testbench/tb.sv
// Self-checking bench for the serial trace capture unit
`timescale 1ns/1ps
module tb;
  reg         clk, reset_n, tx_valid, cfg_write, cmd_on, cmd_off, cmd_reset;
  reg         cfg_pkt_count_given, cfg_opcode_given;
  reg         cfg_byte_count_given, cfg_value_given;
  reg  [1:0]  cfg_mode;
  reg  [7:0]  tx_data, cfg_opcode, cfg_value;
  reg  [15:0] cfg_pkt_count, cfg_byte_count;
  reg  [9:0]  rd_addr;
  wire        rx_valid, pkt_start, rd_dir, armed, capturing, full, overrun;
  wire [7:0]  rx_data, pkt_opcode, rd_data;
  wire [9:0]  fill_level;
  integer     i, cycles, err_total, n_checks;

  stc_laptop i_stc_laptop (.clk, .rx_valid, .rx_data, .pkt_start,
    .pkt_opcode);
  stc_trace i_stc_trace (.clk, .reset_n, .rx_valid, .rx_data, .tx_valid,
    .tx_data, .pkt_start, .pkt_opcode, .cfg_write, .cfg_mode,
    .cfg_pkt_count_given, .cfg_pkt_count, .cfg_opcode_given, .cfg_opcode,
    .cfg_byte_count_given, .cfg_byte_count, .cfg_value_given, .cfg_value,
    .cmd_on, .cmd_off, .cmd_reset, .rd_addr, .rd_data, .rd_dir, .armed,
    .capturing, .full, .fill_level, .overrun);

  // 10 MHz clock
  always #50 clk = ~clk;

  task tick(input integer n);
    repeat (n) @(posedge clk);
  endtask

  task chk(input [15:0] got, input [15:0] exp);
  begin
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task tx(input [7:0] b);
  begin
    @(posedge clk);
    tx_valid <= 1'b1;
    tx_data  <= b;
    @(posedge clk);
    tx_valid <= 1'b0;
    tx_data  <= ~b;
  end
  endtask

  // Command strobe: 0 enable, 1 disable, 2 clear and re-arm
  task cmd(input [1:0] k);
  begin
    @(posedge clk);
    cmd_on    <= (k == 2'h0);
    cmd_off   <= (k == 2'h1);
    cmd_reset <= (k == 2'h2);
    @(posedge clk);
    {cmd_on, cmd_off, cmd_reset} <= 3'h0;
    tick(3);
  end
  endtask

  // Zero count means not given; bit 8 of op and v marks given
  task setup(input [1:0] m, input [15:0] pc, input [8:0] op,
             input [15:0] bc, input [8:0] v);
  begin
    @(posedge clk);
    cfg_write <= 1'b1;
    cfg_mode  <= m;
    {cfg_pkt_count_given, cfg_pkt_count} <= {|pc, pc};
    {cfg_opcode_given, cfg_opcode} <= op;
    {cfg_byte_count_given, cfg_byte_count} <= {|bc, bc};
    {cfg_value_given, cfg_value} <= v;
    @(posedge clk);
    cfg_write <= 1'b0;
    tick(3);
    chk(armed, 1'b1);
  end
  endtask

  task slot(input [9:0] a, input [7:0] d, input dir);
  begin
    @(posedge clk);
    rd_addr <= a;
    tick(2);
    chk(rd_data, d);
    chk(rd_dir, dir);
  end
  endtask

  task t_bytes;
  begin
    setup(2'h1, 16'h0, 9'h000, 16'h0, 9'h000);
    i_stc_laptop.send(8'h10, 1'b0);
    tx(8'h11);
    i_stc_laptop.send(8'h12, 1'b0);
    tick(3);
    chk(capturing, 1'b0);
    tx(8'h13);
    i_stc_laptop.send(8'h14, 1'b0);
    tick(5);
    chk(capturing, 1'b1);
    slot(10'h000, 8'h13, 1'b1);
    slot(10'h001, 8'h14, 1'b0);
  end
  endtask

  task t_pkt;
  begin
    setup(2'h0, 16'h2, 9'h107, 16'h0, 9'h000);
    i_stc_laptop.send(8'h05, 1'b1);
    i_stc_laptop.send(8'h07, 1'b1);
    tick(3);
    chk(capturing, 1'b0);
    i_stc_laptop.send(8'h07, 1'b1);
    tick(4);
    chk(capturing, 1'b1);
    slot(10'h002, 8'h07, 1'b0);
    setup(2'h0, 16'h0, 9'h000, 16'h0, 9'h000);
    i_stc_laptop.send(8'h3c, 1'b1);
    tick(4);
    chk(capturing, 1'b1);
  end
  endtask

  task t_order;
  begin
    setup(2'h2, 16'h0, 9'h000, 16'h1, 9'h12a);
    i_stc_laptop.send(8'h2a, 1'b0);
    i_stc_laptop.send(8'h01, 1'b1);
    tick(3);
    chk(capturing, 1'b0);
    i_stc_laptop.send(8'h2a, 1'b0);
    tick(4);
    chk(capturing, 1'b1);
    setup(2'h3, 16'h0, 9'h000, 16'h1, 9'h12a);
    i_stc_laptop.send(8'h01, 1'b1);
    i_stc_laptop.send(8'h2a, 1'b0);
    tick(3);
    chk(capturing, 1'b0);
    i_stc_laptop.send(8'h01, 1'b1);
    tick(4);
    chk(capturing, 1'b1);
    // Both directions in one cycle while capturing: tx is lost
    fork
      i_stc_laptop.send(8'h55, 1'b0);
      tx(8'h66);
    join
    tick(2);
    chk(overrun, 1'b1);
  end
  endtask

  task t_full;
  begin
    cmd(2'h2);
    setup(2'h1, 16'h0, 9'h000, 16'h1, 9'h000);
    i_stc_laptop.send(8'ha0, 1'b0);
    i_stc_laptop.send(8'ha1, 1'b0);
    cmd(2'h1);
    i_stc_laptop.send(8'ha2, 1'b0);
    tick(5);
    chk(fill_level, 10'h002);
    slot(10'h001, 8'ha1, 1'b0);
    cmd(2'h0);
    i_stc_laptop.send(8'ha3, 1'b0);
    tick(5);
    chk(fill_level, 10'h003);
    for (i = 0; i < 908; i = i + 1)
      i_stc_laptop.send(i[7:0], 1'b0);
    tick(6);
    chk(full, 1'b1);
    chk(fill_level, 10'h38e);
    slot(10'h38d, 8'h8a, 1'b0);
    slot(10'h3ff, 8'h00, 1'b0);
    cmd(2'h2);
    chk(fill_level, 10'h000);
    chk(armed, 1'b1);
    chk(full, 1'b0);
    chk(overrun, 1'b0);
  end
  endtask

  task finish_test;
  begin
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 6000)
    begin
      err_total = err_total + 1;
      finish_test;
    end
  end

  // Reset for three cycles, then the scenarios
  initial
  begin
    {clk, reset_n, tx_valid, cfg_write, cmd_on, cmd_off, cmd_reset} = 7'h0;
    {cfg_pkt_count_given, cfg_opcode_given} = 2'h0;
    {cfg_byte_count_given, cfg_value_given, cfg_mode} = 4'h0;
    {tx_data, cfg_opcode, cfg_value} = 24'h0;
    {cfg_pkt_count, cfg_byte_count, rd_addr} = 42'h0;
    {i, cycles, err_total, n_checks} = 128'h0;
    tick(3);
    reset_n <= 1'b1;
    tick(1);
    t_bytes;
    t_pkt;
    t_order;
    t_full;
    finish_test;
  end
endmodule // tb
